//--- hw/cpu_opcode_decode_slice.sv
// Decode slice: opcode fetch, operand bytes, address forming, low power ops.
// Function
// - Opcode 9F copies index into accumulator in two cycles, flags kept.
// - Opcode 8F clears interrupt mask and halts CPU clock, two cycles.
// - Short indexed offset: one byte, address is index plus unsigned byte.
// - Long indexed offset: high then low byte, added to index.
// - Extended: high then low address byte form the operand address.
// - Bit test branch: direct address byte then signed relative offset.
// - High nibble picks group and mode, low nibble picks operation.
// - Column A-F: immediate, direct, extended, long, short, zero indexed.
// - Opcode 8E clears interrupt mask and stops oscillator, two cycles.
module cpu_opcode_decode_slice
    import opcode_decode_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        byteValid,
    input  wire logic [7:0]  byteData,
    input  wire logic [7:0]  indexIn,
    input  wire logic        wakeUp,
    output logic [7:0]       accOut,
    output logic [7:0]       condCodeOut,
    output logic [15:0]      effAddr,
    output logic             effAddrValid,
    output logic [7:0]       branchOffset,
    output logic [3:0]       modeOut,
    output logic [3:0]       operationOut,
    output logic             instrDone,
    output logic             cpuClockHalt,
    output logic             oscStop
);
    // ========================================================================
    // Opcode map
    // ========================================================================
    addr_mode_t  mode;
    reg_mem_op_t operation;
    logic        bitTestBranch;
    logic [7:0]  opcode_q, opcode_d;

    nibble_map u_map (
        .opcode        (opcode_q),
        .mode          (mode),
        .operation     (operation),
        .bitTestBranch (bitTestBranch)
    );

    // ========================================================================
    // State
    // ========================================================================
    dec_state_t  state_q, state_d;
    logic [7:0]  opnd1_q, opnd1_d;
    logic [7:0]  acc_q, acc_d;
    logic [7:0]  cc_q, cc_d;
    logic [15:0] addr_q, addr_d;
    logic        addrValid_q, addrValid_d;
    logic [7:0]  rel_q, rel_d;
    logic [3:0]  modeOut_q, modeOut_d;
    logic [3:0]  opOut_q, opOut_d;
    logic        done_q, done_d;
    logic        halt_q, halt_d;
    logic        osc_q, osc_d;

    // ========================================================================
    // Address adders
    // ========================================================================
    // Both sums wrap at sixteen bits like the address space itself; the
    // carry out of the top bit is dropped on purpose.
    logic [15:0] shortSum;
    logic [15:0] longSum;
    assign shortSum = 16'({8'h00, indexIn} + {8'h00, byteData});
    assign longSum  = 16'({opnd1_q, byteData} + {8'h00, indexIn});

    // Next state: operand byte count comes from the decoded column.
    always_comb begin
        state_d     = state_q;
        opcode_d    = opcode_q;
        opnd1_d     = opnd1_q;
        acc_d       = acc_q;
        cc_d        = cc_q;
        addr_d      = addr_q;
        addrValid_d = 1'b0;
        rel_d       = rel_q;
        modeOut_d   = modeOut_q;
        opOut_d     = opOut_q;
        done_d      = 1'b0;
        halt_d      = halt_q;
        osc_d       = osc_q;
        unique case (state_q)
            ST_FETCH: begin
                // Only the three inherent opcodes skip the operand states;
                // every other opcode passes through them.
                if (byteValid) begin
                    opcode_d = byteData;
                    if (byteData == OP_XFER_INDEX_TO_ACC
                        || byteData == OP_WAIT
                        || byteData == OP_STOP) begin
                        state_d = ST_INHERENT;
                    end else begin
                        state_d = ST_OPND1;
                    end
                end
            end
            ST_OPND1: begin
                modeOut_d = opcode_q[7:4];
                opOut_d   = operation;
                // Zero offset needs no operand byte; a byte offered in this
                // cycle is not taken, so the source must hold it one more.
                if (mode == indexed_zero_offset_mode) begin
                    addr_d      = {8'h00, indexIn};
                    addrValid_d = 1'b1;
                    done_d      = 1'b1;
                    state_d     = ST_FETCH;
                end else if (byteValid) begin
                    opnd1_d = byteData;
                    if (mode == indexed_short_offset_mode) begin
                        // Unsigned offset; carry into the high byte kept.
                        addr_d      = shortSum;
                        addrValid_d = 1'b1;
                        done_d      = 1'b1;
                        state_d     = ST_FETCH;
                    end else if (mode == direct_mode
                                 || mode == immediate_mode) begin
                        addr_d      = {8'h00, byteData};
                        addrValid_d = 1'b1;
                        done_d      = 1'b1;
                        state_d     = ST_FETCH;
                    end else begin
                        state_d = ST_OPND2;
                    end
                end
            end
            ST_OPND2: begin
                // Second byte: low address or offset byte, or branch offset.
                if (byteValid) begin
                    addrValid_d = 1'b1;
                    done_d      = 1'b1;
                    state_d     = ST_FETCH;
                    if (bitTestBranch) begin
                        addr_d = {8'h00, opnd1_q};
                        rel_d  = byteData;
                    end else if (mode == indexed_long_offset_mode) begin
                        addr_d = longSum;
                    end else begin
                        addr_d = {opnd1_q, byteData};
                    end
                end
            end
            ST_INHERENT: begin
                // Second of the two inherent cycles completes the work.
                done_d = 1'b1;
                if (opcode_q == OP_XFER_INDEX_TO_ACC) begin
                    acc_d   = indexIn;
                    state_d = ST_FETCH;
                end else if (opcode_q == OP_WAIT) begin
                    cc_d[CC_IMASK_BIT] = 1'b0;
                    halt_d  = 1'b1;
                    state_d = ST_WAITING;
                end else begin
                    cc_d[CC_IMASK_BIT] = 1'b0;
                    osc_d   = 1'b1;
                    state_d = ST_STOPPED;
                end
            end
            ST_WAITING, ST_STOPPED: begin
                // Only a wake-up event leaves the low power states.
                if (wakeUp) begin
                    halt_d  = 1'b0;
                    osc_d   = 1'b0;
                    state_d = ST_FETCH;
                end
            end
            default: state_d = ST_FETCH;
        endcase
    end

    // ========================================================================
    // Registers
    // ========================================================================
    // Registers only; every output is a flip-flop.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q     <= ST_FETCH;
            opcode_q    <= 8'h00;
            opnd1_q     <= 8'h00;
            acc_q       <= 8'h00;
            cc_q        <= CC_RESET;
            addr_q      <= 16'h0000;
            addrValid_q <= 1'b0;
            rel_q       <= 8'h00;
            modeOut_q   <= 4'h0;
            opOut_q     <= 4'h0;
            done_q      <= 1'b0;
            halt_q      <= 1'b0;
            osc_q       <= 1'b0;
        end else begin
            state_q     <= state_d;
            opcode_q    <= opcode_d;
            opnd1_q     <= opnd1_d;
            acc_q       <= acc_d;
            cc_q        <= cc_d;
            addr_q      <= addr_d;
            addrValid_q <= addrValid_d;
            rel_q       <= rel_d;
            modeOut_q   <= modeOut_d;
            opOut_q     <= opOut_d;
            done_q      <= done_d;
            halt_q      <= halt_d;
            osc_q       <= osc_d;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    // Ports are plain wires from the registers above, so no output can
    // carry a glitch from the next-state logic.
    assign accOut       = acc_q;
    assign condCodeOut  = cc_q;
    assign effAddr      = addr_q;
    assign effAddrValid = addrValid_q;
    assign branchOffset = rel_q;
    assign modeOut      = modeOut_q;
    assign operationOut = opOut_q;
    assign instrDone    = done_q;
    assign cpuClockHalt = halt_q;
    assign oscStop      = osc_q;
endmodule

//--- hw/nibble_map.sv
// Combinational map from opcode nibbles to addressing mode and operation.
module nibble_map
    import opcode_decode_pkg::*;
(
    input  wire logic [7:0] opcode,
    output addr_mode_t      mode,
    output reg_mem_op_t     operation,
    output logic            bitTestBranch
);
    // ========================================================================
    // Nibble decode
    // ========================================================================
    // High nibble picks the column, low nibble picks the operation.
    always_comb begin
        operation     = reg_mem_op_t'(opcode[3:0]);
        bitTestBranch = (opcode[7:4] == NIB_BIT_TEST_BRANCH);
        unique case (opcode[7:4])
            NIB_IMMEDIATE: mode = immediate_mode;
            NIB_DIR:       mode = direct_mode;
            NIB_EXTENDED:  mode = extended_mode;
            NIB_IDX_LONG:  mode = indexed_long_offset_mode;
            NIB_IDX_SHORT: mode = indexed_short_offset_mode;
            NIB_IDX_ZERO:  mode = indexed_zero_offset_mode;
            default: mode = MODE_NONE;
        endcase
    end
endmodule

//--- inc/opcode_decode_pkg.sv
// Package with opcode map constants and decode enumerations.
package opcode_decode_pkg;
    // ========================================================================
    // Opcode values
    // ========================================================================
    localparam logic [7:0] OP_XFER_INDEX_TO_ACC = 8'h9F;
    localparam logic [7:0] OP_WAIT              = 8'h8F;
    localparam logic [7:0] OP_STOP              = 8'h8E;
    localparam logic [3:0] NIB_BIT_TEST_BRANCH  = 4'h0;
    localparam logic [3:0] NIB_IMMEDIATE        = 4'hA;
    localparam logic [3:0] NIB_DIR              = 4'hB;
    localparam logic [3:0] NIB_EXTENDED         = 4'hC;
    localparam logic [3:0] NIB_IDX_LONG         = 4'hD;
    localparam logic [3:0] NIB_IDX_SHORT        = 4'hE;
    localparam logic [3:0] NIB_IDX_ZERO         = 4'hF;
    // Condition code bit position of the interrupt mask.
    localparam int         CC_IMASK_BIT         = 3;
    localparam logic [7:0] CC_RESET             = 8'hE8;
    localparam logic [2:0] INHERENT_CYCLES      = 3'h2;

    // ========================================================================
    // Types
    // ========================================================================
    typedef enum logic [6:0] {
        MODE_NONE          = 7'h01,
        immediate_mode     = 7'h02,
        direct_mode        = 7'h04,
        extended_mode      = 7'h08,
        indexed_long_offset_mode  = 7'h10,
        indexed_short_offset_mode = 7'h20,
        indexed_zero_offset_mode  = 7'h40
    } addr_mode_t;

    typedef enum logic [3:0] {
        ALU_SUBTRACT   = 4'h0, ALU_COMPARE    = 4'h1,
        ALU_SUB_CARRY  = 4'h2, ALU_CMP_INDEX  = 4'h3,
        ALU_AND        = 4'h4, ALU_BIT_TEST   = 4'h5,
        ALU_LOAD_ACC   = 4'h6, ALU_STORE_ACC  = 4'h7,
        ALU_XOR        = 4'h8, ALU_ADD_CARRY  = 4'h9,
        ALU_OR         = 4'hA, ALU_ADD        = 4'hB,
        ALU_JUMP       = 4'hC, ALU_CALL       = 4'hD,
        ALU_LOAD_INDEX = 4'hE, ALU_STORE_INDEX = 4'hF
    } reg_mem_op_t;

    typedef enum logic [6:0] {
        ST_FETCH   = 7'h01,
        ST_OPND1   = 7'h02,
        ST_OPND2   = 7'h04,
        ST_INHERENT = 7'h08,
        ST_DONE    = 7'h10,
        ST_WAITING = 7'h20,
        ST_STOPPED = 7'h40
    } dec_state_t;
endpackage

//--- sim/opcode_decode_checker.sv
// Port level checker for the opcode decode slice.
module opcode_decode_checker (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        wakeUp,
    input wire logic [7:0]  indexIn,
    input wire logic [7:0]  accOut,
    input wire logic [7:0]  condCodeOut,
    input wire logic [15:0] effAddr,
    input wire logic        effAddrValid,
    input wire logic [3:0]  modeOut,
    input wire logic        instrDone,
    input wire logic        cpuClockHalt,
    input wire logic        oscStop
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // ========================================================================
    // Low power sequences
    // ========================================================================
    // Only a wake request may end a halt or a stop.
    sequence haltHeld;
        cpuClockHalt && !wakeUp;
    endsequence
    sequence stopHeld;
        oscStop && !wakeUp;
    endsequence
    // Only the mask bit may ever move; the other flags keep reset state.
    AST_FLAGS_KEPT: assert property
        ((condCodeOut & 8'hF7) == 8'hE0)
        else $error("condition flags other than the mask changed");
    AST_ACC_ON_DONE: assert property (!$stable(accOut) |-> instrDone)
        else $error("accumulator moved outside an instruction end");
    AST_HALT_HOLD: assert property (haltHeld |=> cpuClockHalt)
        else $error("halt dropped without a wake request");
    AST_HALT_MASK: assert property (cpuClockHalt |-> !condCodeOut[3])
        else $error("halted with the interrupt mask set");
    AST_STOP_HOLD: assert property (stopHeld |=> oscStop)
        else $error("stop dropped without a wake request");
    AST_STOP_MASK: assert property (oscStop |-> !condCodeOut[3])
        else $error("stopped with the interrupt mask set");
    AST_ADDR_DONE: assert property (effAddrValid |-> instrDone)
        else $error("address pulse without instruction end");
    AST_DONE_PULSE: assert property (instrDone |=> !instrDone)
        else $error("instruction end longer than one cycle");
    // Zero offset forms its address from the index alone.
    AST_ZERO_IDX: assert property (effAddrValid && modeOut == 4'hF
        |-> effAddr == {8'h00, indexIn})
        else $error("zero offset address differs from index");
endmodule

bind cpu_opcode_decode_slice opcode_decode_checker chk_i (
    .clk(clk), .reset_n(reset_n), .wakeUp(wakeUp), .indexIn(indexIn),
    .accOut(accOut), .condCodeOut(condCodeOut), .effAddr(effAddr),
    .effAddrValid(effAddrValid), .modeOut(modeOut), .instrDone(instrDone),
    .cpuClockHalt(cpuClockHalt), .oscStop(oscStop)
);

//--- sim/tb.sv
// Self-checking testbench for the opcode decode slice.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import opcode_decode_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, byteValid = 1'b0, wakeUp = 1'b0;
    logic [7:0] byteData = 8'h00, indexIn = 8'h00, accOut, condCodeOut;
    logic [7:0] branchOffset;
    logic [15:0] effAddr;
    logic [3:0] modeOut, operationOut;
    logic effAddrValid, instrDone, cpuClockHalt, oscStop;
    int failCount = 0, compares = 0, cycles = 0;
    logic [3:0] hiTab [7] = '{4'h0, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
    logic [7:0] op, b1, b2;

    cpu_opcode_decode_slice cpu_opcode_decode_slice_i (.clk(clk),
        .reset_n(reset_n), .byteValid(byteValid), .byteData(byteData),
        .indexIn(indexIn), .wakeUp(wakeUp), .accOut(accOut),
        .condCodeOut(condCodeOut), .effAddr(effAddr),
        .effAddrValid(effAddrValid), .branchOffset(branchOffset),
        .modeOut(modeOut), .operationOut(operationOut),
        .instrDone(instrDone), .cpuClockHalt(cpuClockHalt),
        .oscStop(oscStop));

    // ========================================================================
    // Clock, timeout and helpers
    // ========================================================================
    // Clock at 100 MHz; a hang is cut short after a generous cycle count.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failCount++;
            finish_test();
        end
    end
    task automatic check(input string name, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Operand bytes that follow the opcode in each column.
    function automatic int opnds(logic [7:0] o);
        if (o[7:4] == 4'h8 || o[7:4] == 4'h9 || o[7:4] == 4'hF) return 0;
        return (o[7:4] == 4'h0 || o[7:4] == 4'hC || o[7:4] == 4'hD) ? 2 : 1;
    endfunction
    function automatic logic [15:0] expAddr(logic [7:0] o, a, b, x);
        case (o[7:4])
            4'hC: return {a, b};
            4'hD: return {a, b} + {8'h00, x};
            4'hE: return {8'h00, x} + {8'h00, a};
            4'hF: return {8'h00, x};
            default: return {8'h00, a};
        endcase
    endfunction
    // Sends one instruction and checks its outcome on the falling edge,
    // where the registered outputs have settled.
    task automatic runOp(input logic [7:0] o, a, b, x);
        int k = 0;
        int n;
        byteValid <= 1'b1;
        byteData <= o;
        indexIn <= x;
        for (int i = 0; i < opnds(o); i++) begin
            @(posedge clk);
            byteData <= (i == 0) ? a : b;
        end
        do begin
            @(posedge clk);
            if (k == 0) byteValid <= 1'b0;
            k++;
            @(negedge clk);
        end while (instrDone !== 1'b1 && k < 20);
        // Edges from the last byte taken up to the end pulse.
        n = (opnds(o) == 0) ? int'(INHERENT_CYCLES) : 1;
        check("latency", 16'(k), 16'(n));
        if (o[7:4] != 4'h8 && o[7:4] != 4'h9) begin
            check("addrValid", {15'h0, effAddrValid}, 16'h1);
            check("effAddr", effAddr, expAddr(o, a, b, x));
            if (o[7:4] == 4'h0) begin
                check("branch", {8'h00, branchOffset}, {8'h00, b});
            end else begin
                check("mode", {12'h0, modeOut}, {12'h0, o[7:4]});
                check("operation", {12'h0, operationOut},
                      {12'h0, o[3:0]});
            end
        end
        // Back to a rising edge, so the next request starts on one.
        @(posedge clk);
    endtask
    task automatic doReset();
        reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
    endtask
    // Confirms the low power state has ended three cycles after the wake request.
    task automatic wake(input string name);
        repeat (3) @(posedge clk);
        check(name, {14'h0, oscStop, cpuClockHalt}, 16'h0);
        $display("test %s done", name);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        void'($urandom(55608));
        doReset();
        runOp(OP_STOP, 8'h00, 8'h00, 8'h11);
        check("stop", {7'h00, oscStop, condCodeOut}, 16'h01E0);
        repeat (2) @(posedge clk);
        wakeUp <= 1'b1;
        @(posedge clk);
        wakeUp <= 1'b0;
        wake("stop");
        doReset();
        runOp(OP_XFER_INDEX_TO_ACC, 8'h00, 8'h00, 8'hC3);
        check("xfer", {accOut, condCodeOut}, 16'hC3E8);
        $display("test xfer done");
        runOp(OP_WAIT, 8'h00, 8'h00, 8'h22);
        check("wait", {7'h00, cpuClockHalt, condCodeOut}, 16'h01E0);
        repeat (2) @(posedge clk);
        wakeUp <= 1'b1;
        @(posedge clk);
        wakeUp <= 1'b0;
        wake("wait");
        runOp(8'hD0, 8'hFF, 8'hFF, 8'h01);
        runOp(8'hE6, 8'hFF, 8'h00, 8'hFF);
        runOp(8'h05, 8'h40, 8'h80, 8'h00);
        $display("test corners done");
        for (int i = 0; i < 60; i++) begin
            op = {hiTab[$urandom % 7], 4'($urandom)};
            b1 = 8'($urandom);
            b2 = 8'($urandom);
            runOp(op, b1, b2, 8'($urandom));
        end
        $display("test random done");
        finish_test();
    end
endmodule
